//--- core/cpwx_core.sv
`timescale 1ns/1ps
// What this block and its controller do
// R1 - Outbound second command word top nibble zero
// R2 - Controller leaves control bits 15..12 unchanged
// R3 - Outbound words one, two fully usable
// R4 - Outbound word four: twelve low bits only
// R5 - Word three carries internal traffic only
// R6 - Authority bit low: ignore all commands
// R7 - Controller always drives authority bit high; the bench controller model drops it every fourth exchange
// R8 - Inbound second condition word top nibble zero
// R9 - Safety bits void without safety capability
// R10 - Standstill bit: immediate, braking after ramp
// R11 - Reduced speed bit high, low while ramping
// R12 - Inbound word four: ten low bits free
// R13 - Inbound word one carries fault flag
// R14 - Bad number, index, value raise fault
// R15 - Refuse safety parameter writes over channel
// R16 - Controller reads back written parameters
// R17 - Request edge starts transfer; busy during
// R18 - Two acknowledgements clear fault number memory
// R19 - Four 16-bit words exchanged per cycle
module cpwx_core
(
   input  wire logic                          mclk,
   input  wire logic                          nrst,
   input  wire logic                          bus_cycle,
   input  wire logic [cpwx_pkg::CPWX_WORD_W-1:0] ctl_cmd1,
   input  wire logic [cpwx_pkg::CPWX_WORD_W-1:0] ctl_setpoint,
   input  wire logic [cpwx_pkg::CPWX_WORD_W-1:0] ctl_cmd2,
   input  wire logic [cpwx_pkg::CPWX_WORD_W-1:0] int_word3_out,
   output logic      [cpwx_pkg::CPWX_WORD_W-1:0] pzd_out1,
   output logic      [cpwx_pkg::CPWX_WORD_W-1:0] pzd_out2,
   output logic      [cpwx_pkg::CPWX_WORD_W-1:0] pzd_out3,
   output logic      [cpwx_pkg::CPWX_WORD_W-1:0] pzd_out4,
   output logic                               cmd_accept,
   input  wire logic [cpwx_pkg::CPWX_WORD_W-1:0] drv_cond1,
   input  wire logic [cpwx_pkg::CPWX_WORD_W-1:0] drv_actual,
   input  wire logic [cpwx_pkg::CPWX_WORD_W-1:0] drv_cond2,
   input  wire logic [cpwx_pkg::CPWX_WORD_W-1:0] int_word3_in,
   input  wire logic                          safety_capable,
   input  wire logic                          safe_standstill,
   input  wire logic                          safe_braking_ramp,
   input  wire logic                          safely_reduced_speed,
   input  wire logic                          ramping_down,
   output logic      [cpwx_pkg::CPWX_WORD_W-1:0] pzd_in1,
   output logic      [cpwx_pkg::CPWX_WORD_W-1:0] pzd_in2,
   output logic      [cpwx_pkg::CPWX_WORD_W-1:0] pzd_in3,
   output logic      [cpwx_pkg::CPWX_WORD_W-1:0] pzd_in4,
   input  wire logic                          par_req,
   input  wire logic                          par_write,
   input  wire logic [cpwx_pkg::CPWX_PNUM_W-1:0] par_number,
   input  wire logic [cpwx_pkg::CPWX_PIDX_W-1:0] par_index,
   input  wire logic [cpwx_pkg::CPWX_PVAL_W-1:0] par_value,
   input  wire logic                          par_num_ok,
   input  wire logic                          par_idx_ok,
   input  wire logic                          par_val_ok,
   input  wire logic                          par_is_safety,
   input  wire logic [cpwx_pkg::CPWX_PVAL_W-1:0] par_read_value,
   input  wire logic                          par_fault_ack,
   output logic                               par_busy,
   output logic                               par_wr_stb,
   output logic      [cpwx_pkg::CPWX_PVAL_W-1:0] par_read_data,
   output logic                               parameter_fault_flag,
   output logic      [cpwx_pkg::CPWX_ERRNO_W-1:0] par_fault_no,
   input  wire logic                          fault_ack,
   input  wire logic                          fault_new,
   input  wire logic [cpwx_pkg::CPWX_FNUM_W-1:0] fault_number_in,
   output logic      [cpwx_pkg::CPWX_FNUM_W-1:0] fault_number_memory,
   output logic                               fault_valid
);
   import cpwx_pkg::*;

   logic                    req_q;        // Request delayed, for edge detect
   logic                    req_rise;     // Rising edge of request
   cpwx_state_e             state_q;      // Parameter handshake state
   logic [2:0]              xfer_cnt_q;   // Busy duration counter
   logic                    dir_wr_q;     // Latched direction
   logic [CPWX_ERRNO_W-1:0] chk_err;      // Error found on the request
   logic                    ack_q;        // Previous fault acknowledge
   logic [1:0]              ack_cnt_q;    // Acknowledge edges seen
   logic [CPWX_WORD_W-1:0]  cond2_q;      // Assembled second condition word

   // Command authority from the first command word
   assign cmd_accept = ctl_cmd1[CPWX_AUTH_B];  // [R6] [R7]

   // Outbound words latched per fieldbus cycle; words one, two and four only with authority, word three always
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         pzd_out1 <= CPWX_WORD_RST;
         pzd_out2 <= CPWX_WORD_RST;
         pzd_out3 <= CPWX_WORD_RST;
         pzd_out4 <= CPWX_WORD_RST;
      end
      else if (bus_cycle)  // [R19]
      begin
         // Commands without authority are dropped, previous words held
         if (ctl_cmd1[CPWX_AUTH_B])  // [R6]
         begin
            pzd_out1 <= ctl_cmd1;      // [R3]
            pzd_out2 <= ctl_setpoint;  // [R3]
            // Top nibble reserved; only low twelve bits reach the drive
            pzd_out4 <= {4'h0, ctl_cmd2[CPWX_CMD2_USER_W-1:0]};  // [R1] [R4] [R2]
         end
         // Internal traffic flows regardless of user authority
         pzd_out3 <= int_word3_out;  // [R5]
      end
   end

   // Second condition word: safety bits only on capable units
   always_comb
   begin
      cond2_q = {4'h0, 2'b00, drv_cond2[CPWX_COND2_USER_W-1:0]};  // [R8] [R12]
      if (safety_capable)  // [R9]
      begin
         // Standstill immediate; braking ramp only once down ramp ends
         cond2_q[CPWX_SAFE_SSTILL_B] = safe_standstill | (safe_braking_ramp & ~ramping_down);  // [R10]
         // Reduced speed suppressed while still ramping
         cond2_q[CPWX_SAFE_SRS_B] = safely_reduced_speed & ~ramping_down;  // [R11]
      end
   end

   // Inbound words latched per fieldbus cycle
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         pzd_in1 <= CPWX_WORD_RST;
         pzd_in2 <= CPWX_WORD_RST;
         pzd_in3 <= CPWX_WORD_RST;
         pzd_in4 <= CPWX_WORD_RST;
      end
      else if (bus_cycle)  // [R19]
      begin
         pzd_in1 <= drv_cond1;     // [R13]
         pzd_in2 <= drv_actual;    // [R3]
         pzd_in3 <= int_word3_in;  // [R5]
         pzd_in4 <= cond2_q;       // [R8]
      end
   end

   // Request edge detector
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         req_q <= 1'b0;
      else
         req_q <= par_req;
   end
   assign req_rise = par_req & ~req_q;  // [R17]

   // Request check; safety refusal only matters on writes
   always_comb
   begin
      if (!par_num_ok)
         chk_err = CPWX_ERR_PNUM;  // [R14]
      else if (!par_idx_ok)
         chk_err = CPWX_ERR_INDEX;  // [R14]
      else if (par_write && !par_val_ok)
         chk_err = CPWX_ERR_RANGE;  // [R14]
      else if (par_write && par_is_safety)
         chk_err = CPWX_ERR_SAFETY;  // [R15]
      else
         chk_err = CPWX_ERR_NONE;
   end

   // Parameter transfer sequencer
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         state_q              <= CPWX_ST_IDLE;
         xfer_cnt_q           <= 3'h0;
         dir_wr_q             <= 1'b0;
         par_wr_stb           <= 1'b0;
         par_read_data        <= 32'h00000000;
         parameter_fault_flag <= 1'b0;
         par_fault_no         <= CPWX_ERR_NONE;
      end
      else
      begin
         par_wr_stb <= 1'b0;
         case (state_q)
            CPWX_ST_IDLE:
            begin
               // New transfers wait until any error is acknowledged
               if (req_rise && !parameter_fault_flag)  // [R17]
               begin
                  dir_wr_q   <= par_write;
                  xfer_cnt_q <= 3'(CPWX_XFER_CYC - 1);
                  if (chk_err != CPWX_ERR_NONE)
                  begin
                     parameter_fault_flag <= 1'b1;  // [R14] [R15]
                     par_fault_no         <= chk_err;
                  end
                  else
                     state_q <= CPWX_ST_BUSY;
               end
               else if (par_fault_ack)
               begin
                  parameter_fault_flag <= 1'b0;
                  par_fault_no         <= CPWX_ERR_NONE;
               end
            end
            CPWX_ST_BUSY:
            begin
               // Busy holds for a fixed transfer time
               if (xfer_cnt_q == 3'h0)
                  state_q <= CPWX_ST_DONE;
               else
                  xfer_cnt_q <= xfer_cnt_q - 3'h1;
            end
            CPWX_ST_DONE:
            begin
               if (dir_wr_q)
                  par_wr_stb <= 1'b1;  // Only validated writes commit
               else
                  par_read_data <= par_read_value;
               state_q <= CPWX_ST_IDLE;
            end
            default:
               state_q <= CPWX_ST_IDLE;
         endcase
      end
   end
   assign par_busy = (state_q != CPWX_ST_IDLE);  // [R17]

   // Fault number memory; a new fault beats a clear in the same cycle
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         ack_q               <= 1'b0;
         ack_cnt_q           <= CPWX_ACK_RST;
         fault_number_memory <= CPWX_WORD_RST;
         fault_valid         <= 1'b0;
      end
      else
      begin
         ack_q <= fault_ack;
         if (fault_new)
         begin
            fault_number_memory <= fault_number_in;
            fault_valid         <= 1'b1;
            ack_cnt_q           <= CPWX_ACK_RST;
         end
         else if (fault_ack && !ack_q && fault_valid)
         begin
            // Second acknowledge wipes the stored fault number and its valid flag together
            if (ack_cnt_q == 2'h1)  // [R18]
            begin
               fault_number_memory <= CPWX_WORD_RST;
               fault_valid         <= 1'b0;
               ack_cnt_q           <= CPWX_ACK_RST;
            end
            else
               ack_cnt_q <= 2'h1;
         end
      end
   end

   // Assertions
   AST_CMD2_NIBBLE: assert property (@(posedge mclk) disable iff (!nrst) pzd_out4[15:12] == 4'h0)  // [R1]
      else $error("outbound word four top nibble not zero");
   AST_COND2_NIBBLE: assert property (@(posedge mclk) disable iff (!nrst) pzd_in4[15:12] == 4'h0)  // [R8]
      else $error("inbound word four top nibble not zero");
   AST_NO_AUTH: assert property (@(posedge mclk) disable iff (!nrst)
      bus_cycle && !ctl_cmd1[10] |=> $stable(pzd_out1) && $stable(pzd_out4))  // [R6]
      else $error("command taken without authority");
   AST_SAFETY_VOID: assert property (@(posedge mclk) disable iff (!nrst)
      bus_cycle && !safety_capable |=> pzd_in4[11:10] == 2'b00)  // [R9]
      else $error("safety bits set on non-safety unit");
   AST_STANDSTILL: assert property (@(posedge mclk) disable iff (!nrst)
      bus_cycle && safety_capable && safe_standstill |=> pzd_in4[10])  // [R10]
      else $error("standstill bit not set");
   AST_SRS_RAMP: assert property (@(posedge mclk) disable iff (!nrst)
      bus_cycle && ramping_down |=> !pzd_in4[11])  // [R11]
      else $error("reduced speed bit high while ramping");
   sequence s_good_start;
      req_rise && !par_busy && !parameter_fault_flag && chk_err == CPWX_ERR_NONE;
   endsequence
   AST_BUSY_SPAN: assert property (@(posedge mclk) disable iff (!nrst)
      s_good_start |=> par_busy [*5] ##1 !par_busy)  // [R17]
      else $error("busy span wrong");
   AST_SAFE_REFUSE: assert property (@(posedge mclk) disable iff (!nrst)
      req_rise && !par_busy && !parameter_fault_flag && par_write && par_is_safety
      |=> parameter_fault_flag && !par_busy)  // [R15]
      else $error("safety write not refused");
   AST_BAD_NUM: assert property (@(posedge mclk) disable iff (!nrst)
      req_rise && !par_busy && !parameter_fault_flag && !par_num_ok |=> par_fault_no == CPWX_ERR_PNUM)  // [R14]
      else $error("bad number not flagged");
   AST_TWO_ACK: assert property (@(posedge mclk) disable iff (!nrst)
      fault_ack && !ack_q && fault_valid && ack_cnt_q == 2'h1 && !fault_new |=> !fault_valid)  // [R18]
      else $error("fault memory not cleared");
endmodule : cpwx_core

//--- core/cpwx_pkg.sv
package cpwx_pkg;
   // Process word geometry
   localparam int          CPWX_WORD_W        = 16;               // Width of one cyclic process word
   localparam int          CPWX_CMD2_USER_W   = 12;               // Usable low bits of outbound word four
   localparam int          CPWX_COND2_USER_W  = 10;               // Free low bits of inbound word four
   localparam int          CPWX_SAFE_SSTILL_B = 10;               // Safe standstill bit in second condition word
   localparam int          CPWX_SAFE_SRS_B    = 11;               // Reduced speed bit in second condition word
   localparam int          CPWX_AUTH_B        = 10;               // Command authority bit in first command word
   localparam int          CPWX_FAULT_B       = 3;                // Fault active bit in first condition word
   // Parameter channel
   localparam int          CPWX_PNUM_W        = 16;               // Parameter number width
   localparam int          CPWX_PIDX_W        = 8;                // Parameter index width
   localparam int          CPWX_PVAL_W        = 32;               // Parameter value width
   localparam int          CPWX_ERRNO_W       = 8;                // Parameter error number width
   localparam int          CPWX_FNUM_W        = 16;               // Fault number width
   localparam int          CPWX_XFER_CYC      = 4;                // Cycles spent in the busy state; par_busy stays high one cycle longer
   // Parameter error numbers
   localparam logic [7:0]  CPWX_ERR_NONE      = 8'h00;            // No error
   localparam logic [7:0]  CPWX_ERR_PNUM      = 8'h01;            // Nonexistent parameter number
   localparam logic [7:0]  CPWX_ERR_INDEX     = 8'h02;            // Invalid index
   localparam logic [7:0]  CPWX_ERR_RANGE     = 8'h03;            // Value out of range
   localparam logic [7:0]  CPWX_ERR_SAFETY    = 8'h04;            // Safety parameter write refused
   // Reset values
   localparam logic [15:0] CPWX_WORD_RST      = 16'h0000;         // Process word reset value
   localparam logic [1:0]  CPWX_ACK_RST       = 2'h0;             // Acknowledge counter reset value

   // Parameter handshake states
   typedef enum logic [2:0]
   {
      CPWX_ST_IDLE = 3'b001,
      CPWX_ST_BUSY = 3'b010,
      CPWX_ST_DONE = 3'b100
   } cpwx_state_e;
endpackage : cpwx_pkg

//--- tb/cpwx_ctl_model.sv
`timescale 1ns/1ps
// Controller side: builds the outbound command words from user content
module cpwx_ctl_model
#(
   parameter logic [3:0] TOP_NIB = 4'hF  // Held constant, all ones to stress the suppression
)
(
   input  wire logic        auth_off,    // Scenario-only: drop command authority
   input  wire logic [15:0] user_cmd1,   // User part of first command word
   input  wire logic [15:0] user_setp,   // Main setpoint
   input  wire logic [11:0] user_cmd2,   // Usable part of second command word
   output logic      [15:0] ctl_cmd1,    // First command word
   output logic      [15:0] ctl_setpoint, // Setpoint word
   output logic      [15:0] ctl_cmd2     // Second command word
);
   // Authority bit forced high unless a scenario drops it on purpose
   assign ctl_cmd1     = {user_cmd1[15:11], ~auth_off, user_cmd1[9:0]};
   // Setpoint passes whole
   assign ctl_setpoint = user_setp;
   // Top nibble never altered, only the low twelve bits carry content
   assign ctl_cmd2     = {TOP_NIB, user_cmd2};
endmodule : cpwx_ctl_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the process word exchange
module tb_top;
   import cpwx_pkg::*;
   logic        mclk, nrst, bus_cycle, auth_off, safety_capable, safe_standstill, safe_braking_ramp;
   logic        safely_reduced_speed, ramping_down, par_req, par_write, par_num_ok, par_idx_ok;
   logic        par_val_ok, par_is_safety, par_fault_ack, fault_ack, fault_new;
   logic [15:0] user_cmd1, user_setp, int_word3_out, drv_cond1, drv_actual, drv_cond2, int_word3_in;
   logic [15:0] ctl_cmd1, ctl_setpoint, ctl_cmd2, pzd_out1, pzd_out2, pzd_out3, pzd_out4;
   logic [15:0] pzd_in1, pzd_in2, pzd_in3, pzd_in4, par_number, fault_number_in, fault_number_memory;
   logic [11:0] user_cmd2;
   logic [7:0]  par_index, par_fault_no;
   logic [31:0] par_value, par_read_value, par_read_data;
   logic        cmd_accept, par_busy, par_wr_stb, parameter_fault_flag, fault_valid;
   logic [15:0] hold1, hold2, hold4;     // Outbound words before a refused cycle
   int          bad_count = 0;           // Mismatches
   int          tests_run = 0;           // Comparisons
   int          seed = 2171;             // Fixed seed, repeatable run
   int          cyc = 0;                 // Hang guard

   // Far side model
   cpwx_ctl_model u_cpwx_ctl_model (.auth_off, .user_cmd1, .user_setp, .user_cmd2, .ctl_cmd1, .ctl_setpoint,
      .ctl_cmd2);
   cpwx_core u_cpwx_core (.mclk, .nrst, .bus_cycle, .ctl_cmd1, .ctl_setpoint, .ctl_cmd2, .int_word3_out,
      .pzd_out1, .pzd_out2, .pzd_out3, .pzd_out4, .cmd_accept, .drv_cond1, .drv_actual, .drv_cond2,
      .int_word3_in, .safety_capable, .safe_standstill, .safe_braking_ramp, .safely_reduced_speed,
      .ramping_down, .pzd_in1, .pzd_in2, .pzd_in3, .pzd_in4, .par_req, .par_write, .par_number, .par_index,
      .par_value, .par_num_ok, .par_idx_ok, .par_val_ok, .par_is_safety, .par_read_value, .par_fault_ack,
      .par_busy, .par_wr_stb, .par_read_data, .parameter_fault_flag, .par_fault_no, .fault_ack, .fault_new,
      .fault_number_in, .fault_number_memory, .fault_valid);

   // Clock, 50 ns period
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Cut a hang short; whole run needs well under a thousand cycles
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         bad_count = bad_count + 1;
         report_and_stop();
      end
   end

   // Single compare point
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   // Expected inbound word four; safety bits void without capability
   function automatic logic [15:0] exp_in4(input logic [15:0] c2, input logic cap, ss, br, srs, rd);
      logic b10, b11;
      b10 = cap & (ss | (br & ~rd));
      b11 = cap & srs & ~rd;
      return {4'h0, b11, b10, c2[9:0]};
   endfunction : exp_in4

   // One parameter request; code is the expected error, none for a good one
   task automatic par_xfer(input logic wr, input logic [3:0] ok, input logic [7:0] code);
      @(posedge mclk);
      par_write <= wr;
      {par_num_ok, par_idx_ok, par_val_ok, par_is_safety} <= ok;
      par_number <= 16'($random(seed));
      par_index <= 8'($random(seed));
      // Reads keep the last written value, so a read checks it back
      par_value <= wr ? $random(seed) : par_value;
      par_read_value <= par_value;
      par_req <= 1'b1;
      @(posedge mclk);
      #1;
      if (code != CPWX_ERR_NONE)
      begin
         chk({22'h0, parameter_fault_flag, par_busy, par_fault_no}, {22'h0, 2'b10, code}, "param error");
         @(posedge mclk);
         par_req <= 1'b0;
         par_fault_ack <= 1'b1;
         @(posedge mclk);
         par_fault_ack <= 1'b0;
         #1;
         chk({31'h0, parameter_fault_flag}, 32'h0, "error acknowledged");
      end
      else
      begin
         // Busy for five cycles, then strobe or read data
         for (int k = 0; k < 5; k++)
         begin
            chk({31'h0, par_busy}, 32'h1, "busy");
            @(posedge mclk);
            par_req <= 1'b0;
            #1;
         end
         chk({30'h0, par_busy, par_wr_stb}, {30'h0, 1'b0, wr}, "end of transfer");
         if (!wr)
            chk(par_read_data, par_value, "read back");
      end
   endtask : par_xfer

   initial
   begin
      {bus_cycle, auth_off, safety_capable, safe_standstill, safe_braking_ramp, safely_reduced_speed} = '0;
      {ramping_down, par_req, par_write, par_num_ok, par_idx_ok, par_val_ok, par_is_safety} = '0;
      {par_fault_ack, fault_ack, fault_new, user_cmd1, user_setp, int_word3_out, drv_cond1} = '0;
      {drv_actual, drv_cond2, int_word3_in, user_cmd2, par_number, par_index, par_value} = '0;
      {par_read_value, fault_number_in} = '0;
      nrst = 1'b0;
      // Reset seen low on two edges, released at the second
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      #1;
      chk({pzd_out1, pzd_in1}, 32'h0, "reset value");
      chk({pzd_out4, pzd_in4}, 32'h0, "reset value four");
      // Random exchanges; every safety combination, authority dropped every fourth
      for (int i = 0; i < 40; i++)
      begin
         @(posedge mclk);
         hold1 = pzd_out1;
         hold2 = pzd_out2;
         hold4 = pzd_out4;
         user_cmd1 <= 16'($random(seed));
         user_setp <= 16'($random(seed));
         user_cmd2 <= 12'($random(seed));
         {int_word3_out, int_word3_in} <= $random(seed);
         {drv_cond1, drv_actual} <= $random(seed);
         drv_cond2 <= 16'($random(seed));
         {safety_capable, safe_standstill, safe_braking_ramp, safely_reduced_speed, ramping_down} <= i[4:0];
         auth_off <= (i % 4 == 3);
         bus_cycle <= 1'b1;
         @(posedge mclk);
         bus_cycle <= 1'b0;
         #1;
         chk({31'h0, cmd_accept}, {31'h0, ~auth_off}, "authority");
         if (auth_off)
            chk({pzd_out1, pzd_out4}, {hold1, hold4}, "refused words held");
         else
            chk({pzd_out1, pzd_out4}, {ctl_cmd1, 4'h0, user_cmd2}, "outbound one four");
         chk(32'(pzd_out2), auth_off ? 32'(hold2) : 32'(user_setp), "setpoint word");
         chk({pzd_out3, pzd_in3}, {int_word3_out, int_word3_in}, "word three");
         chk({pzd_in1, pzd_in2}, {drv_cond1, drv_actual}, "inbound one two");
         chk(32'(pzd_in4), 32'(exp_in4(drv_cond2, safety_capable, safe_standstill, safe_braking_ramp,
            safely_reduced_speed, ramping_down)), "inbound four");
      end
      // Parameter channel: good transfers and every error code by priority
      par_xfer(1'b1, 4'b1110, CPWX_ERR_NONE);
      par_xfer(1'b0, 4'b1110, CPWX_ERR_NONE);
      par_xfer(1'b1, 4'b0000, CPWX_ERR_PNUM);
      par_xfer(1'b0, 4'b1000, CPWX_ERR_INDEX);
      par_xfer(1'b1, 4'b1101, CPWX_ERR_RANGE);
      par_xfer(1'b1, 4'b1111, CPWX_ERR_SAFETY);
      par_xfer(1'b0, 4'b1111, CPWX_ERR_NONE);
      // Fault memory: stored, survives one acknowledge, cleared by the second
      @(posedge mclk);
      fault_number_in <= 16'($random(seed));
      fault_new <= 1'b1;
      @(posedge mclk);
      fault_new <= 1'b0;
      #1;
      chk({15'h0, fault_valid, fault_number_memory}, {15'h0, 1'b1, fault_number_in}, "fault stored");
      for (int a = 0; a < 2; a++)
      begin
         @(posedge mclk);
         fault_ack <= 1'b1;
         @(posedge mclk);
         fault_ack <= 1'b0;
         @(posedge mclk);
         #1;
         chk({15'h0, fault_valid, fault_number_memory}, (a == 0) ? {15'h0, 1'b1, fault_number_in} : 32'h0,
            "fault after acknowledge");
      end
      report_and_stop();
   end
endmodule : tb_top
